//--- rtl/ctmc_pkg.sv
// Package: constants and carrier types of the CAN transceiver mode control.
// Assumes a single 40 MHz system clock; no register bus of its own beyond APB.
package ctmc_pkg;
   // -----------------------------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFS   = 8'h00;
   localparam logic [7:0] STAT_OFFS   = 8'h04;
   localparam logic [7:0] IRQ_OFFS    = 8'h08;
   localparam logic [7:0] MASK_OFFS   = 8'h0C;
   // Control fields
   localparam int CTRL_STBY_POS   = 0;
   localparam int CTRL_TXD_POS    = 1;
   localparam int CTRL_COND_POS   = 2;
   localparam logic [2:0] CTRL_RESET = 3'h3;
   // Event bits, shared by status and mask
   localparam int EV_WAKE_POS    = 0;
   localparam int EV_THERM_POS   = 1;
   localparam int EV_TOUT_POS    = 2;
   localparam int EV_WIDTH       = 3;
   localparam logic [2:0] MASK_RESET = 3'h0;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ           = 40_000_000;
   localparam int WAKE_FILTER_NS   = 1000;
   localparam int WAKE_FILTER_CYC  = (WAKE_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int DOM_TIMEOUT_US   = 1000;
   localparam int DOM_TIMEOUT_CYC  = DOM_TIMEOUT_US * (CLK_HZ / 1_000_000);
   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_NORMAL  = 4'b0001,
      ST_ARMING  = 4'b0010,
      ST_WATCH   = 4'b0100,
      ST_WOKEN   = 4'b1000
   } ctmc_state_t;
   typedef struct packed {
      logic drive_dom;
      logic rx_data;
      logic split_en;
      logic bus_gnd;
   } ctmc_line_t;
endpackage

//--- rtl/ctmc_top.sv
// Top of the CAN transceiver mode control: pin logic plus APB control.
// Assumes pins arrive synchronous to clk_sys_i; synchronisers still applied.
// Assumes an APB master that holds each request until pready.
// Overview of operation
// - standby select low normal, high standby; normal also needs the ctrl_reg standby bit clear, which reset sets
// - normal mode: txd low drives dominant
// - normal mode: rxd follows bus level
// - unconnected txd and standby default high
// - standby disables transmitter and receiver
// - standby wake after filtered dominant, rxd low
// - standby terminates bus lines to ground
// - split output driven only in normal
// - unconditioned variant wakes on standing dominant
// - conditioned variant needs recessive first
// - wake reported only; stays standby
// - over temperature switches off transmitter only
// - thermal off latched until txd high
// - timeout timer starts on txd fall
// - txd low too long disables transmitter
// - txd rise resets timer, re-enables
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ctmc_top #(
   parameter int WAKE_CYC    = ctmc_pkg::WAKE_FILTER_CYC,
   parameter int TIMEOUT_CYC = ctmc_pkg::DOM_TIMEOUT_CYC
) (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        txd_i,
   input  wire logic        txd_conn_i,
   input  wire logic        standby_select_i,
   input  wire logic        stby_conn_i,
   input  wire logic        bus_dom_i,
   input  wire logic        over_temp_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             bus_drive_dom_o,
   output logic             bus_gnd_term_o,
   output logic             common_mode_split_out_o,
   output logic             rxd_o,
   output logic             irq_o
);
   localparam int WCW = $clog2(WAKE_CYC + 1);
   localparam int TCW = $clog2(TIMEOUT_CYC + 1);

   // -----------------------------------------------------------------
   // Input synchronisers
   // -----------------------------------------------------------------
   logic [1:0] txd_sync_reg;
   logic [1:0] stb_sync_reg;
   logic [1:0] bus_sync_reg;
   logic       txd_q_reg;
   logic       txd_eff;
   logic       stb_eff;
   assign txd_eff = txd_conn_i ? txd_i : 1'b1;
   assign stb_eff = stby_conn_i ? standby_select_i : 1'b1;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         txd_sync_reg <= 2'h3;
         stb_sync_reg <= 2'h3;
         bus_sync_reg <= 2'h0;
         txd_q_reg    <= 1'b1;
      end else begin
         txd_sync_reg <= {txd_sync_reg[0], txd_eff};
         stb_sync_reg <= {stb_sync_reg[0], stb_eff};
         bus_sync_reg <= {bus_sync_reg[0], bus_dom_i};
         txd_q_reg    <= txd_sync_reg[1];
      end
   end
   logic txd_s;
   logic stb_s;
   logic dom_s;
   logic txd_fall;
   logic txd_rise;
   assign txd_s    = txd_sync_reg[1];
   assign stb_s    = stb_sync_reg[1];
   assign dom_s    = bus_sync_reg[1];
   assign txd_fall = txd_q_reg & ~txd_s;
   assign txd_rise = ~txd_q_reg & txd_s;

   // -----------------------------------------------------------------
   // APB control registers
   // -----------------------------------------------------------------
   logic [2:0]                 ctrl_reg;
   logic [ctmc_pkg::EV_WIDTH-1:0] irq_stat_reg;
   logic [ctmc_pkg::EV_WIDTH-1:0] irq_mask_reg;
   logic [ctmc_pkg::EV_WIDTH-1:0] ev_set;
   logic                       wr_en;
   logic                       rd_en;
   logic                       hit;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign hit   = (paddr == ctmc_pkg::CTRL_OFFS) | (paddr == ctmc_pkg::STAT_OFFS)
                | (paddr == ctmc_pkg::IRQ_OFFS)  | (paddr == ctmc_pkg::MASK_OFFS);
   // Conditioned variant bit lets one die serve both wake flavours
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctrl_reg     <= ctmc_pkg::CTRL_RESET;
         irq_mask_reg <= ctmc_pkg::MASK_RESET;
      end else if (wr_en) begin
         if (paddr == ctmc_pkg::CTRL_OFFS) begin
            ctrl_reg <= pwdata[2:0];
         end
         if (paddr == ctmc_pkg::MASK_OFFS) begin
            irq_mask_reg <= pwdata[ctmc_pkg::EV_WIDTH-1:0];
         end
      end
   end
   // Set wins over write-one-to-clear
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         irq_stat_reg <= '0;
      end else if (wr_en && paddr == ctmc_pkg::IRQ_OFFS) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata[ctmc_pkg::EV_WIDTH-1:0]) | ev_set;
      end else begin
         irq_stat_reg <= irq_stat_reg | ev_set;
      end
   end
   // Software may also override pins: both must agree for normal mode
   logic stby_req;
   logic txd_req;
   logic cond_mode;
   assign stby_req  = stb_s | ctrl_reg[ctmc_pkg::CTRL_STBY_POS];
   assign txd_req   = txd_s & ctrl_reg[ctmc_pkg::CTRL_TXD_POS];
   assign cond_mode = ctrl_reg[ctmc_pkg::CTRL_COND_POS];

   // -----------------------------------------------------------------
   // Mode and wake state machine
   // -----------------------------------------------------------------
   ctmc_pkg::ctmc_state_t state_reg;
   ctmc_pkg::ctmc_state_t state_next;
   logic [WCW-1:0]        wake_cnt_reg;
   logic                  wake_hit;
   assign wake_hit = (wake_cnt_reg == WCW'(WAKE_CYC));
   always_comb begin
      case (state_reg)
         ctmc_pkg::ST_NORMAL: begin
            if (!stby_req) state_next = ctmc_pkg::ST_NORMAL;
            else if (cond_mode && dom_s) state_next = ctmc_pkg::ST_ARMING;
            else state_next = ctmc_pkg::ST_WATCH;
         end
         ctmc_pkg::ST_ARMING: begin
            if (!stby_req) state_next = ctmc_pkg::ST_NORMAL;
            else if (!dom_s) state_next = ctmc_pkg::ST_WATCH;
            else state_next = ctmc_pkg::ST_ARMING;
         end
         ctmc_pkg::ST_WATCH: begin
            if (!stby_req) state_next = ctmc_pkg::ST_NORMAL;
            else if (wake_hit) state_next = ctmc_pkg::ST_WOKEN;
            else state_next = ctmc_pkg::ST_WATCH;
         end
         ctmc_pkg::ST_WOKEN: begin
            if (!stby_req) state_next = ctmc_pkg::ST_NORMAL;
            else state_next = ctmc_pkg::ST_WOKEN;
         end
         default: state_next = ctmc_pkg::ST_NORMAL;
      endcase
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) state_reg <= ctmc_pkg::ST_NORMAL;
      else state_reg <= state_next;
   end
   // unconditioned counts standing dominant at once
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wake_cnt_reg <= '0;
      end else if (state_reg == ctmc_pkg::ST_WATCH && dom_s && !wake_hit) begin
         wake_cnt_reg <= wake_cnt_reg + WCW'(1);
      end else if (state_reg != ctmc_pkg::ST_WATCH || !dom_s) begin
         wake_cnt_reg <= '0;
      end
   end

   // -----------------------------------------------------------------
   // Transmitter protection
   // -----------------------------------------------------------------
   logic           therm_off_reg;
   logic           tout_off_reg;
   logic [TCW-1:0] tout_cnt_reg;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) therm_off_reg <= 1'b0;
      else if (over_temp_i) therm_off_reg <= 1'b1;
      else if (txd_s) therm_off_reg <= 1'b0;
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || txd_rise || txd_fall || txd_s) begin
         tout_cnt_reg <= '0;
      end else if (tout_cnt_reg != TCW'(TIMEOUT_CYC)) begin
         tout_cnt_reg <= tout_cnt_reg + TCW'(1);
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || txd_rise) tout_off_reg <= 1'b0;
      else if (tout_cnt_reg == TCW'(TIMEOUT_CYC)) tout_off_reg <= 1'b1;
   end
   assign ev_set = {tout_cnt_reg == TCW'(TIMEOUT_CYC) && !tout_off_reg,
                    over_temp_i && !therm_off_reg,
                    state_next == ctmc_pkg::ST_WOKEN && state_reg != ctmc_pkg::ST_WOKEN};

   // -----------------------------------------------------------------
   // Line outputs, all registered
   // -----------------------------------------------------------------
   ctmc_pkg::ctmc_line_t line_next;
   logic                 is_normal;
   assign is_normal = (state_next == ctmc_pkg::ST_NORMAL);
   always_comb begin
      line_next.drive_dom = is_normal & ~txd_req & ~therm_off_reg & ~tout_off_reg & ~over_temp_i;
      line_next.rx_data   = is_normal ? ~dom_s : (state_next != ctmc_pkg::ST_WOKEN);
      line_next.split_en  = is_normal;
      line_next.bus_gnd   = ~is_normal;
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         bus_drive_dom_o         <= 1'b0;
         rxd_o                   <= 1'b1;
         common_mode_split_out_o <= 1'b0;
         bus_gnd_term_o          <= 1'b1;
         irq_o                   <= 1'b0;
         prdata                  <= '0;
         pready                  <= 1'b0;
         pslverr                 <= 1'b0;
      end else begin
         bus_drive_dom_o         <= line_next.drive_dom;
         rxd_o                   <= line_next.rx_data;
         common_mode_split_out_o <= line_next.split_en;
         bus_gnd_term_o          <= line_next.bus_gnd;
         irq_o                   <= |(irq_stat_reg & irq_mask_reg);
         // Zero wait state: ready in the cycle after setup
         pready                  <= psel & ~penable;
         pslverr                 <= psel & ~penable & ~hit;
         prdata                  <= '0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               ctmc_pkg::CTRL_OFFS: prdata <= {29'h0, ctrl_reg};
               ctmc_pkg::STAT_OFFS: prdata <= {25'h0, therm_off_reg, tout_off_reg, state_reg, stby_req};
               ctmc_pkg::IRQ_OFFS:  prdata <= {29'h0, irq_stat_reg};
               ctmc_pkg::MASK_OFFS: prdata <= {29'h0, irq_mask_reg};
               default:             prdata <= 32'h0;
            endcase
         end
      end
   end
   logic unused_rd;
   assign unused_rd = rd_en;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   sequence s_stby_long;
      stby_req [*2];
   endsequence
   sequence s_tout_expired;
      (tout_cnt_reg == TCW'(TIMEOUT_CYC)) && !txd_s;
   endsequence
   sequence s_tx_cut;
      tout_off_reg ##1 !bus_drive_dom_o;
   endsequence
   sequence s_tout_cleared;
      !tout_off_reg && tout_cnt_reg == '0;
   endsequence
   sequence s_wake_due;
      state_reg == ctmc_pkg::ST_WATCH && stby_req && wake_hit;
   endsequence

   // -----------------------------------------------------------------
   // Mode and line output checks
   // -----------------------------------------------------------------
   mode_normal_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !stby_req |=> state_reg == ctmc_pkg::ST_NORMAL) else $error("normal mode not taken");
   mode_standby_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      stby_req |=> state_reg != ctmc_pkg::ST_NORMAL) else $error("standby not taken");
   tx_dominant_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (is_normal && !txd_req && !therm_off_reg && !tout_off_reg && !over_temp_i) |=> bus_drive_dom_o)
      else $error("dominant not driven");
   tx_recessive_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      txd_req |=> !bus_drive_dom_o) else $error("dominant while txd high");
   rxd_normal_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      is_normal |=> rxd_o == !$past(dom_s)) else $error("rxd not following bus");
   open_txd_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !txd_conn_i |=> txd_sync_reg[0]) else $error("open txd not high");
   open_stby_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !stby_conn_i |=> stb_sync_reg[0]) else $error("open standby not high");
   no_tx_standby_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !is_normal |=> !bus_drive_dom_o) else $error("transmit in standby");
   gnd_term_standby_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(state_next != ctmc_pkg::ST_NORMAL) |-> bus_gnd_term_o) else $error("no ground termination");
   gnd_off_normal_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      is_normal |=> !bus_gnd_term_o) else $error("ground termination in normal");
   split_only_normal_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_stby_long |=> !common_mode_split_out_o) else $error("split driven in standby");
   split_normal_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      is_normal |=> common_mode_split_out_o) else $error("split not driven");

   // -----------------------------------------------------------------
   // Wake-up checks
   // -----------------------------------------------------------------
   wake_filter_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ctmc_pkg::ST_WATCH && !wake_hit) |=> state_reg != ctmc_pkg::ST_WOKEN) else $error("short wake");
   wake_rxd_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_wake_due |=> !rxd_o) else $error("wake not shown");
   rxd_standby_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!is_normal && state_next != ctmc_pkg::ST_WOKEN) |=> rxd_o) else $error("rxd low without wake");
   uncond_entry_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ctmc_pkg::ST_NORMAL && stby_req && !cond_mode) |=> state_reg == ctmc_pkg::ST_WATCH)
      else $error("unconditioned entry not watching");
   cond_arm_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ctmc_pkg::ST_NORMAL && stby_req && cond_mode && dom_s) |=> state_reg == ctmc_pkg::ST_ARMING)
      else $error("conditioned entry not arming");
   cond_entry_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ctmc_pkg::ST_ARMING && dom_s && stby_req) |=> state_reg == ctmc_pkg::ST_ARMING)
      else $error("early wake");
   wake_stays_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == ctmc_pkg::ST_WOKEN && stby_req) |=> state_reg == ctmc_pkg::ST_WOKEN) else $error("left standby");

   // -----------------------------------------------------------------
   // Transmitter protection checks
   // -----------------------------------------------------------------
   therm_tx_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      over_temp_i |=> !bus_drive_dom_o) else $error("transmit while hot");
   therm_latch_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (therm_off_reg && !txd_s) |=> therm_off_reg) else $error("thermal off released early");
   therm_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (therm_off_reg && txd_s && !over_temp_i) |=> !therm_off_reg) else $error("thermal off stuck");
   tout_start_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      txd_fall |=> tout_cnt_reg == '0) else $error("timer not restarted");
   tout_count_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!txd_s && !txd_fall && tout_cnt_reg != TCW'(TIMEOUT_CYC)) |=> tout_cnt_reg == $past(tout_cnt_reg) + TCW'(1))
      else $error("timer not counting");
   tout_fire_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      s_tout_expired |=> s_tx_cut) else $error("timeout missed");
   tout_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (tout_off_reg && !txd_rise) |=> tout_off_reg) else $error("timeout off released early");
   tout_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      txd_rise |=> s_tout_cleared) else $error("timeout not cleared");

   // -----------------------------------------------------------------
   // Register bus and interrupt checks
   // -----------------------------------------------------------------
   apb_ready_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (psel && !penable) |=> pready) else $error("pready missing");
   apb_ready_drop_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (psel && penable) |=> !pready) else $error("pready held too long");
   apb_error_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (psel && !penable && !hit) |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   stat_set_wins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (|ev_set) |=> (irq_stat_reg & $past(ev_set)) == $past(ev_set))
      else $error("event lost");
   stat_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_en && paddr == ctmc_pkg::IRQ_OFFS && ev_set == '0) |=> (irq_stat_reg & $past(pwdata[2:0])) == '0)
      else $error("status not cleared");
   irq_level_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      irq_o == $past(|(irq_stat_reg & irq_mask_reg))) else $error("irq level wrong");
endmodule
`default_nettype wire

//--- verification/ctmc_bus_model.sv
// Far side of the mode control: the CAN bus with its other nodes.
// Assumes one clock; other_dom_i stands for dominant bits of far nodes.
`timescale 1ns/100ps
`default_nettype none
module ctmc_bus_model (
   input  wire logic clk_i,
   input  wire logic slow_i,
   input  wire logic drive_dom_i,
   input  wire logic gnd_term_i,
   input  wire logic other_dom_i,
   output logic      bus_dom_o
);
   // ------------------------------------------
   // Wired bus level
   // ------------------------------------------
   logic lvl_reg;
   logic lag_reg;
   always_ff @(posedge clk_i) begin
      lvl_reg <= (drive_dom_i & ~gnd_term_i) | other_dom_i;
      lag_reg <= lvl_reg;
   end
   // Long cable: one extra cycle of lag
   assign bus_dom_o = slow_i ? lag_reg : lvl_reg;
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench of the CAN transceiver mode control.
// Assumes the bus model file; drives pins and APB at rising edges.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ------------------------------------------
   // Signals
   // ------------------------------------------
   logic        clk_sys_i, rst_i, txd_i, txd_conn_i, standby_select_i, stby_conn_i;
   logic        bus_dom_i, over_temp_i, other_dom, slow, psel, penable, pwrite;
   logic        pready, pslverr, bus_drive_dom_o, bus_gnd_term_o;
   logic        common_mode_split_out_o, rxd_o, irq_o, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   int          error_cnt, total_checks, cyc_cnt, m_off, m_woke, m_irq;

   // Short counts keep the run brief
   ctmc_top #(.WAKE_CYC(4), .TIMEOUT_CYC(60)) uut (.clk_sys_i, .rst_i, .txd_i, .txd_conn_i,
      .standby_select_i, .stby_conn_i, .bus_dom_i, .over_temp_i, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_drive_dom_o, .bus_gnd_term_o,
      .common_mode_split_out_o, .rxd_o, .irq_o);
   ctmc_bus_model bus (.clk_i(clk_sys_i), .slow_i(slow), .drive_dom_i(bus_drive_dom_o),
      .gnd_term_i(bus_gnd_term_o), .other_dom_i(other_dom), .bus_dom_o(bus_dom_i));

   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   // ------------------------------------------
   // Tasks
   // ------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Holds the request until pready; one idle cycle after
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys_i);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      apb(1'b0, a, 32'h0);
      cmp(rd, exp);
      cmp({31'h0, err}, {31'h0, experr});
   endtask
   // Pin model: settle, then compare all outputs
   task automatic chk_pins();
      logic s, t, d;
      cyc(10);
      s = standby_select_i | ~stby_conn_i;
      t = txd_i | ~txd_conn_i;
      d = ~s & ~t & (m_off == 0);
      cmp({27'h0, bus_drive_dom_o, bus_gnd_term_o, common_mode_split_out_o, rxd_o, irq_o},
          {27'h0, d, s, ~s, s ? (m_woke == 0) : ~(d | other_dom), m_irq == 1});
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk_sys_i) begin
      cyc_cnt++;
      if (cyc_cnt > 5000) begin
         error_cnt++;
         finish_test();
      end
   end

   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   initial begin
      rst_i = 1'b1; txd_i = 1'b1; txd_conn_i = 1'b1; standby_select_i = 1'b1;
      stby_conn_i = 1'b1; over_temp_i = 1'b0; other_dom = 1'b0; slow = 1'b0;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      seed = 32'h57E6; m_off = 0; m_woke = 0; m_irq = 0;
      cyc(4);
      rst_i <= 1'b0;
      chk_pins();
      rd_chk(8'h00, 32'h3, 1'b0);
      rd_chk(8'h0C, 32'h0, 1'b0);
      rd_chk(8'h10, 32'h0, 1'b1);
      rd_chk(8'h04, 32'h9, 1'b0);
      // Release the software standby hold, keep txd gate open
      apb(1'b1, 8'h00, 32'h2);
      rd_chk(8'h00, 32'h2, 1'b0);
      $display("test reset done");
      standby_select_i <= 1'b0; slow <= 1'b1;
      chk_pins();
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         txd_i <= seed[0] | ~txd_i;
         other_dom <= seed[1];
         chk_pins();
      end
      txd_i <= 1'b1; other_dom <= 1'b0; slow <= 1'b0;
      cyc(4);
      $display("test normal done");
      txd_i <= 1'b0;
      chk_pins();
      over_temp_i <= 1'b1; m_off = 1;
      chk_pins();
      other_dom <= 1'b1;
      chk_pins();
      other_dom <= 1'b0; over_temp_i <= 1'b0;
      chk_pins();
      txd_i <= 1'b1; m_off = 0;
      chk_pins();
      txd_i <= 1'b0;
      chk_pins();
      rd_chk(8'h08, 32'h2, 1'b0);
      apb(1'b1, 8'h08, 32'h2);
      rd_chk(8'h08, 32'h0, 1'b0);
      apb(1'b1, 8'h0C, 32'h4);
      $display("test thermal done");
      cyc(60);
      m_off = 1; m_irq = 1;
      chk_pins();
      rd_chk(8'h08, 32'h4, 1'b0);
      rd_chk(8'h04, 32'h22, 1'b0);
      apb(1'b1, 8'h08, 32'h4);
      m_irq = 0;
      chk_pins();
      txd_i <= 1'b1; m_off = 0;
      chk_pins();
      txd_i <= 1'b0;
      chk_pins();
      txd_i <= 1'b1;
      $display("test timeout done");
      standby_select_i <= 1'b1;
      chk_pins();
      txd_i <= 1'b0;
      chk_pins();
      txd_i <= 1'b1; other_dom <= 1'b1;
      cyc(2);
      other_dom <= 1'b0;
      chk_pins();
      other_dom <= 1'b1; m_woke = 1;
      chk_pins();
      rd_chk(8'h04, 32'h11, 1'b0);
      rd_chk(8'h08, 32'h1, 1'b0);
      apb(1'b1, 8'h08, 32'h1);
      standby_select_i <= 1'b0; other_dom <= 1'b0; m_woke = 0;
      chk_pins();
      other_dom <= 1'b1;
      chk_pins();
      standby_select_i <= 1'b1; m_woke = 1;
      chk_pins();
      standby_select_i <= 1'b0; other_dom <= 1'b0; m_woke = 0;
      chk_pins();
      apb(1'b1, 8'h00, 32'h6);
      other_dom <= 1'b1;
      cyc(8);
      standby_select_i <= 1'b1;
      chk_pins();
      other_dom <= 1'b0;
      chk_pins();
      other_dom <= 1'b1; m_woke = 1;
      chk_pins();
      standby_select_i <= 1'b0; other_dom <= 1'b0; m_woke = 0;
      chk_pins();
      $display("test wake done");
      txd_i <= 1'b0; txd_conn_i <= 1'b0; stby_conn_i <= 1'b0;
      chk_pins();
      $display("test unconnected done");
      finish_test();
   end
endmodule
`default_nettype wire
